/* File: core/loopback_pkg.sv */
// Function
// - Frame control bit 0 written 1 forces LT operation over an NT strap.
// - Ready framer-to-deframer loopback reads 0x0B in activation status.
// - Analog loopback sends input data to line driver, line receive to output.
// - Every reset clears the analog loopback modifier bits.
// - Analog loopback copies eoc, M4 and M5/M6 transmit into receive registers.
// - Register set select 0x01 maps overlay set, 0x00 restores normal set.
// - Overlay pin configuration 0x22 drives superframe sync pin, 0x00 releases.
// - Overlay loopback 0x20 enables analog loopback, 0x00 turns it off.
// - Activated analog loopback reads 0xB in activation status.
package loopback_pkg;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 4;
	// Word indices; byte address is index times four
	localparam logic [3:0] IDX_M4_TX = 4'h0;
	localparam logic [3:0] IDX_M4_RX = 4'h1;
	localparam logic [3:0] IDX_M56_TX = 4'h2;
	localparam logic [3:0] IDX_M56_RX = 4'h3;
	localparam logic [3:0] IDX_EOC_TX = 4'h4;
	localparam logic [3:0] IDX_EOC_RX = 4'h5;
	localparam logic [3:0] IDX_FRAME = 4'h6;
	localparam logic [3:0] IDX_SET_SEL = 4'h7;
	localparam logic [3:0] IDX_ACT_CTRL = 4'h8;
	localparam logic [3:0] IDX_EQ_CTRL = 4'h9;
	localparam logic [3:0] IDX_LOOP_CTRL = 4'hA;
	localparam logic [3:0] IDX_CUST_EN = 4'hB;
	localparam logic [3:0] IDX_ACT_STAT = 4'hC;
	localparam logic [3:0] IDX_OV_MOD = 4'hD;
	localparam logic [3:0] IDX_OV_PIN = 4'hE;
	localparam logic [3:0] IDX_OV_LOOP = 4'hF;
	// Field positions
	localparam int FRAME_LT_BIT = 0;
	localparam int LOOP_F2D_BIT = 4;
	localparam int OV_ANALOG_BIT = 5;
	localparam int CUST_EN_BIT = 0;
	localparam logic [1:0] MOD_BITS_MASK = 2'h3;
	localparam int MOD_LSB = 6;
	// Codes
	localparam logic [7:0] RESET_VAL = 8'h00;
	localparam logic [7:0] SET_OVERLAY = 8'h01;
	localparam logic [7:0] PIN_DRIVE = 8'h22;
	localparam logic [7:0] ACT_F2D = 8'h89;
	localparam logic [7:0] EQ_F2D = 8'h0C;
	localparam logic [7:0] STAT_READY = 8'h0B;
	localparam logic [7:0] STAT_IDLE = 8'h00;
	typedef struct packed {
		logic [7:0] eoc;
		logic [7:0] m4;
		logic [7:0] m56;
	} mchan_s;
endpackage : loopback_pkg

/* File: core/stream_fifo.sv */
`timescale 1ns/1ns
module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_r;
	logic [AW-1:0] rdPtr_r;
	logic [AW:0] count_r;
	wire push = inValid && inReady;
	wire pop = outValid && outReady;
	// Full and empty come straight from the occupancy count
	assign inReady = (count_r != (AW+1)'(DEPTH));
	assign outValid = (count_r != '0);
	assign outData = mem[rdPtr_r];
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wrPtr_r] <= inData;
		end
	end
	// Pointers wrap on the power-of-two depth
	always_ff @(posedge clock) begin
		if (srst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			wrPtr_r <= push ? wrPtr_r + AW'(1) : wrPtr_r;
			rdPtr_r <= pop ? rdPtr_r + AW'(1) : rdPtr_r;
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : stream_fifo

/* File: core/u_loopback_control.sv */
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module u_loopback_control (
	input wire logic clock,
	input wire logic srst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Strap pin, high means strapped as NT
	input wire logic strapNt,
	// TDM serial input bytes
	input wire logic dinValid,
	output logic dinReady,
	input wire logic [7:0] dinData,
	// TDM serial output bytes
	output logic doutValid,
	output logic [7:0] doutData,
	// Line transmit side
	output logic lineTxEn,
	output logic lineTxValid,
	input wire logic lineTxReady,
	output logic [7:0] lineTxData,
	// Line receive side, same clock
	input wire logic lineRxValid,
	input wire logic [7:0] lineRxData,
	input wire logic lineMValid,
	input wire loopback_pkg::mchan_s lineMData,
	// M channel transmit to framer
	output loopback_pkg::mchan_s mTx,
	// Superframe sync pin
	input wire logic sfSyncIn,
	output logic sfSyncOut,
	output logic sfSyncOe,
	output logic ltMode
);
	// Control registers
	logic [7:0] frame_r;
	logic [7:0] setSel_r;
	logic [7:0] actCtrl_r;
	logic [7:0] eqCtrl_r;
	logic [7:0] loopCtrl_r;
	logic [7:0] custEn_r;
	logic [7:0] ovMod_r;
	logic [7:0] ovPin_r;
	logic [7:0] ovLoop_r;
	loopback_pkg::mchan_s mTx_r;
	loopback_pkg::mchan_s mRx_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic [2:0] strapSync_r;
	logic strapNt_r;
	logic sfSyncOe_r;
	logic doutValid_r;
	logic [7:0] doutData_r;
	logic sfSeen_r;

	// Strap passes three flops; a change counts once the last two agree
	always_ff @(posedge clock) begin
		if (srst) begin
			strapSync_r <= 3'h0;
			strapNt_r <= 1'b0;
		end else begin
			strapSync_r <= {strapSync_r[1:0], strapNt};
			strapNt_r <= (strapSync_r[2] == strapSync_r[1]) ? strapSync_r[2] : strapNt_r;
		end
	end

	// Register address decode
	wire [3:0] idx = paddr[5:2];
	wire overlayMapped = (setSel_r == loopback_pkg::SET_OVERLAY);
	wire isOverlay = (idx == loopback_pkg::IDX_OV_MOD) || (idx == loopback_pkg::IDX_OV_PIN) ||
		(idx == loopback_pkg::IDX_OV_LOOP);
	wire inRange = (paddr[31:6] == 26'h0) && (paddr[1:0] == 2'h0);
	wire unmapped = !inRange || (isOverlay && !overlayMapped);
	wire setupPhase = psel && !penable;
	wire wrEn = psel && penable && pwrite && !pslverr_r;
	wire [7:0] wByte = pwdata[7:0];

	// Mode decode
	assign ltMode = !strapNt_r || frame_r[loopback_pkg::FRAME_LT_BIT];
	wire f2dLoop = loopCtrl_r[loopback_pkg::LOOP_F2D_BIT];
	wire analogLoop = ovLoop_r[loopback_pkg::OV_ANALOG_BIT];
	wire custOn = custEn_r[loopback_pkg::CUST_EN_BIT];
	wire f2dReady = f2dLoop && ltMode && custOn && (actCtrl_r == loopback_pkg::ACT_F2D) &&
		(eqCtrl_r == loopback_pkg::EQ_F2D);
	// Activation needs the returned line signal seen at least once
	wire analogReady = analogLoop && ltMode && custOn && sfSeen_r;
	wire [7:0] actStatus = (f2dReady || analogReady) ? loopback_pkg::STAT_READY :
		loopback_pkg::STAT_IDLE;

	// Read multiplexer
	logic [7:0] rdByte;
	always_comb begin
		rdByte = 8'h00;
		unique case (idx)
			loopback_pkg::IDX_M4_TX: rdByte = mTx_r.m4;
			loopback_pkg::IDX_M4_RX: rdByte = mRx_r.m4;
			loopback_pkg::IDX_M56_TX: rdByte = mTx_r.m56;
			loopback_pkg::IDX_M56_RX: rdByte = mRx_r.m56;
			loopback_pkg::IDX_EOC_TX: rdByte = mTx_r.eoc;
			loopback_pkg::IDX_EOC_RX: rdByte = mRx_r.eoc;
			loopback_pkg::IDX_FRAME: rdByte = frame_r;
			loopback_pkg::IDX_SET_SEL: rdByte = setSel_r;
			loopback_pkg::IDX_ACT_CTRL: rdByte = actCtrl_r;
			loopback_pkg::IDX_EQ_CTRL: rdByte = eqCtrl_r;
			loopback_pkg::IDX_LOOP_CTRL: rdByte = loopCtrl_r;
			loopback_pkg::IDX_CUST_EN: rdByte = custEn_r;
			loopback_pkg::IDX_ACT_STAT: rdByte = actStatus;
			loopback_pkg::IDX_OV_MOD: rdByte = ovMod_r;
			loopback_pkg::IDX_OV_PIN: rdByte = ovPin_r;
			loopback_pkg::IDX_OV_LOOP: rdByte = ovLoop_r;
		endcase
	end

	// Read data and error are caught in setup so access answers at once
	always_ff @(posedge clock) begin
		if (srst) begin
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
		end else if (setupPhase) begin
			prdata_r <= unmapped ? 32'h0 : {24'h0, rdByte};
			pslverr_r <= unmapped;
		end
	end
	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = psel && penable && pslverr_r;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
		hit = (a == b);
	endfunction : hit

	// Software-written control registers; srst clears all of them
	always_ff @(posedge clock) begin
		if (srst) begin
			frame_r <= loopback_pkg::RESET_VAL;
			setSel_r <= loopback_pkg::RESET_VAL;
			actCtrl_r <= loopback_pkg::RESET_VAL;
			eqCtrl_r <= loopback_pkg::RESET_VAL;
			loopCtrl_r <= loopback_pkg::RESET_VAL;
			custEn_r <= loopback_pkg::RESET_VAL;
		end else if (wrEn) begin
			frame_r <= hit(idx, loopback_pkg::IDX_FRAME) ? wByte : frame_r;
			setSel_r <= hit(idx, loopback_pkg::IDX_SET_SEL) ? wByte : setSel_r;
			actCtrl_r <= hit(idx, loopback_pkg::IDX_ACT_CTRL) ? wByte : actCtrl_r;
			eqCtrl_r <= hit(idx, loopback_pkg::IDX_EQ_CTRL) ? wByte : eqCtrl_r;
			loopCtrl_r <= hit(idx, loopback_pkg::IDX_LOOP_CTRL) ? wByte : loopCtrl_r;
			custEn_r <= hit(idx, loopback_pkg::IDX_CUST_EN) ? wByte : custEn_r;
		end
	end

	// Overlay registers only take writes while the overlay set is mapped
	always_ff @(posedge clock) begin
		if (srst) begin
			ovMod_r <= loopback_pkg::RESET_VAL;
			ovPin_r <= loopback_pkg::RESET_VAL;
			ovLoop_r <= loopback_pkg::RESET_VAL;
		end else if (wrEn && overlayMapped) begin
			ovMod_r <= hit(idx, loopback_pkg::IDX_OV_MOD) ? wByte : ovMod_r;
			ovPin_r <= hit(idx, loopback_pkg::IDX_OV_PIN) ? wByte : ovPin_r;
			ovLoop_r <= hit(idx, loopback_pkg::IDX_OV_LOOP) ? wByte : ovLoop_r;
		end
	end

	// Modifier bits flatten the receive return slightly; a loose hybrid needs it
	wire [1:0] modBits = ovMod_r[loopback_pkg::MOD_LSB +: 2] & loopback_pkg::MOD_BITS_MASK;

	// M channel transmit registers
	always_ff @(posedge clock) begin
		if (srst) begin
			mTx_r <= '0;
		end else if (wrEn) begin
			mTx_r.m4 <= hit(idx, loopback_pkg::IDX_M4_TX) ? wByte : mTx_r.m4;
			mTx_r.m56 <= hit(idx, loopback_pkg::IDX_M56_TX) ? wByte : mTx_r.m56;
			mTx_r.eoc <= hit(idx, loopback_pkg::IDX_EOC_TX) ? wByte : mTx_r.eoc;
		end
	end
	assign mTx = mTx_r;

	// Whole superframe loops back, so receive mirrors transmit in either loop
	wire loopM = analogLoop || f2dLoop;
	always_ff @(posedge clock) begin
		if (srst) begin
			mRx_r <= '0;
		end else if (loopM) begin
			mRx_r <= mTx_r;
		end else if (lineMValid) begin
			mRx_r <= lineMData;
		end
	end

	// B and D path: input bytes buffered, then routed by mode
	logic fifoValid;
	logic fifoReady;
	logic [7:0] fifoData;
	stream_fifo #(
		.WIDTH(loopback_pkg::DATA_W),
		.DEPTH(loopback_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.srst(srst),
		.inValid(dinValid),
		.inReady(dinReady),
		.inData(dinData),
		.outValid(fifoValid),
		.outReady(fifoReady),
		.outData(fifoData)
	);

	// Driver is off in framer-to-deframer loop so nothing reaches the line
	assign lineTxEn = !f2dLoop;
	assign lineTxValid = lineTxEn && fifoValid;
	assign lineTxData = fifoData;
	// Internal loop drains the FIFO every cycle; line path stalls on the driver
	assign fifoReady = f2dLoop ? 1'b1 : lineTxReady;

	// Output stream: internal loop from FIFO, otherwise recovered line data
	wire [7:0] rxShaped = (modBits != 2'h0) ? {lineRxData[7:1], lineRxData[0] & !modBits[0]} :
		lineRxData;
	always_ff @(posedge clock) begin
		if (srst) begin
			doutValid_r <= 1'b0;
			doutData_r <= 8'h00;
		end else if (f2dLoop) begin
			doutValid_r <= fifoValid;
			doutData_r <= fifoData;
		end else begin
			doutValid_r <= lineRxValid;
			doutData_r <= analogLoop ? rxShaped : lineRxData;
		end
	end
	assign doutValid = doutValid_r;
	assign doutData = doutData_r;

	// Returned signal seen in analog loop marks activation
	always_ff @(posedge clock) begin
		if (srst || !analogLoop) begin
			sfSeen_r <= 1'b0;
		end else if (lineRxValid) begin
			sfSeen_r <= 1'b1;
		end
	end

	// Sync pin driven low only on the exact enabling code
	always_ff @(posedge clock) begin
		if (srst) begin
			sfSyncOe_r <= 1'b0;
		end else begin
			sfSyncOe_r <= (ovPin_r == loopback_pkg::PIN_DRIVE);
		end
	end
	assign sfSyncOe = sfSyncOe_r;
	// Pin input is not used here; the pulldown level is what we replace
	assign sfSyncOut = 1'b0 & sfSyncIn;
endmodule : u_loopback_control

/* File: verification/u_loopback_control_asserts.sv */
`timescale 1ns/1ns
module u_loopback_control_asserts (
	input wire logic clock,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic strapNt,
	input wire logic lineTxEn,
	input wire logic lineTxValid,
	input wire logic lineRxValid,
	input wire logic doutValid,
	input wire logic sfSyncOut,
	input wire logic sfSyncOe,
	input wire logic ltMode
);
	logic loopOn_r, ltBit_r;
	logic [7:0] sel_r, pin_r;
	// Overlay words decode only while the overlay set is mapped
	wire logic [3:0] idx = paddr[5:2];
	wire logic bad = paddr[31:6] != '0 || paddr[1:0] != '0 || (idx > 4'hC && sel_r != 8'h01);
	wire logic wr = psel && penable && pwrite && pready && !bad;
	// Shadows follow accepted writes only, so refused ones cannot leak in
	always_ff @(posedge clock) begin
		if (srst) begin
			{loopOn_r, ltBit_r, sel_r, pin_r} <= '0;
		end else if (wr) begin
			if (idx == 4'hA) loopOn_r <= pwdata[4];
			if (idx == 4'h6) ltBit_r <= pwdata[0];
			if (idx == 4'h7) sel_r <= pwdata[7:0];
			if (idx == 4'hE) pin_r <= pwdata[7:0];
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	property p_ltForce; ltBit_r |-> ltMode; endproperty
	a_ltForce: assert property (p_ltForce) else $error("LT not forced");
	property p_ltStrap; (!strapNt) [*4] |=> ltMode; endproperty
	a_ltStrap: assert property (p_ltStrap) else $error("LT strap lost");
	property p_txOff; lineTxEn == !loopOn_r; endproperty
	a_txOff: assert property (p_txOff) else $error("driver enable wrong");
	property p_txIdle; lineTxValid |-> lineTxEn; endproperty
	a_txIdle: assert property (p_txIdle) else $error("line sent while off");
	property p_err; pslverr == (psel && penable && bad); endproperty
	a_err: assert property (p_err) else $error("slave error wrong");
	property p_ready; psel && penable |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("no ready");
	property p_pin; $past(!srst) |-> sfSyncOe == $past(pin_r == 8'h22) && !sfSyncOut; endproperty
	a_pin: assert property (p_pin) else $error("sync pin drive wrong");
	property p_dout; !loopOn_r && $past(!loopOn_r) && $past(!srst) |->
		doutValid == $past(lineRxValid); endproperty
	a_dout: assert property (p_dout) else $error("returned byte lost");
endmodule : u_loopback_control_asserts
bind u_loopback_control u_loopback_control_asserts u_u_loopback_control_asserts (.clock, .srst,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .strapNt, .lineTxEn,
	.lineTxValid, .lineRxValid, .doutValid, .sfSyncOut, .sfSyncOe, .ltMode);

/* File: verification/line_echo.sv */
`timescale 1ns/1ns
module line_echo (
	input wire logic clock,
	input wire logic srst,
	input wire logic hold,
	input wire logic lineTxValid,
	input wire logic [7:0] lineTxData,
	output logic lineTxReady,
	output logic lineRxValid,
	output logic [7:0] lineRxData
);
	logic odd_r;
	wire logic take = lineTxValid && lineTxReady;
	// Ready every other cycle, never while held, so the driver meets stalls
	assign lineTxReady = odd_r && !hold;
	// Byte returns a cycle later; between bytes the data inverts, never holds
	always_ff @(posedge clock) begin
		odd_r <= !srst && !odd_r;
		lineRxValid <= !srst && take;
		lineRxData <= srst ? 8'h00 : take ? lineTxData : ~lineRxData;
	end
endmodule : line_echo

/* File: verification/u_loopback_control_test.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin fails++; \
	$display("CHECK FAILED at %0t: %h not %h", $time, a, b); end end
module u_loopback_control_test;
	logic clock = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic strapNt = 1'h0, dinValid = 1'h0, hold = 1'h0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
	logic [7:0] dinData = 8'h00, doutData, lineTxData, lineRxData, rd, d;
	logic pready, pslverr, dinReady, doutValid, lineTxEn, lineTxValid, lineTxReady;
	logic lineRxValid, sfSyncOut, sfSyncOe, ltMode;
	loopback_pkg::mchan_s mTx;
	int fails = 0, nChecks = 0;
	// Even bytes, so the modifier's low-bit clearing cannot hide a fault
	logic [7:0] pat [4] = '{8'h5A, 8'hC4, 8'h3E, 8'hA0};
	logic [7:0] mv [3] = '{8'h82, 8'h3C, 8'h42};
	always #5 clock = ~clock;
	u_loopback_control u_u_loopback_control (.clock, .srst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .strapNt, .dinValid, .dinReady, .dinData,
		.doutValid, .doutData, .lineTxEn, .lineTxValid, .lineTxReady, .lineTxData,
		.lineRxValid, .lineRxData, .lineMValid(1'h0), .lineMData('0), .mTx,
		.sfSyncIn(1'h0), .sfSyncOut, .sfSyncOe, .ltMode);
	line_echo u_line_echo (.clock, .srst, .hold, .lineTxValid, .lineTxData, .lineTxReady,
		.lineRxValid, .lineRxData);
	task automatic completeRun;
		$display("Checks %0d, mismatches %0d", nChecks, fails);
		if (fails == 0 && nChecks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : completeRun
	task automatic bail;
		fails++;
		$display("CHECK FAILED at %0t: wait ran out", $time);
		completeRun();
	endtask : bail
	// Levels are judged at the falling edge, where they have settled
	task automatic waitHi(ref logic s);
		int n;
		@(negedge clock);
		for (n = 0; n < 60 && s !== 1'h1; n++) @(negedge clock);
		if (n == 60) bail();
	endtask : waitHi
	// Request held until pready is seen high at a rising edge; data taken at that edge
	task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] v);
		int n;
		@(posedge clock);
		{psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, 24'h0, v};
		@(posedge clock);
		penable <= 1'h1;
		for (n = 0; n < 60; n++) begin
			@(posedge clock);
			if (pready === 1'h1) break;
		end
		if (n == 60) bail();
		rd = prdata[7:0];
		{psel, penable} <= 2'h0;
	endtask : apb
	task automatic wr(input logic [3:0] i, input logic [7:0] v);
		apb(1'h1, {26'h0, i, 2'h0}, v);
	endtask : wr
	task automatic rdIdx(input logic [3:0] i);
		apb(1'h0, {26'h0, i, 2'h0}, 8'h00);
	endtask : rdIdx
	// Index and value pairs, written in the order given
	task automatic run(input logic [11:0] s [$]);
		foreach (s[k]) wr(s[k][11:8], s[k][7:0]);
	endtask : run
	task automatic poll(input logic [7:0] want);
		for (int n = 0; n < 40; n++) begin
			rdIdx(4'hC);
			if (rd === want) return;
		end
		bail();
	endtask : poll
	task automatic push(input logic [7:0] v);
		@(posedge clock);
		{dinValid, dinData} <= {1'h1, v};
		waitHi(dinReady);
		@(posedge clock);
		dinValid <= 1'h0;
	endtask : push
	task automatic pull;
		waitHi(doutValid);
		d = doutData;
	endtask : pull
	task automatic testRegs;
		rdIdx(4'hD);
		`CHK(rd, 8'h00)
		run({12'h701, 12'hDC0});
		rdIdx(4'hD);
		`CHK(rd, 8'hC0)
		wr(4'h7, 8'h00);
		rdIdx(4'hD);
		`CHK(rd, 8'h00)
		apb(1'h1, 32'h68, 8'h10);
		@(negedge clock);
		`CHK(lineTxEn, 1'h1)
		@(posedge clock);
		srst <= 1'h1;
		repeat (2) @(posedge clock);
		srst <= 1'h0;
		wr(4'h7, 8'h01);
		rdIdx(4'hD);
		`CHK(rd, 8'h00)
		wr(4'h7, 8'h00);
		$display("testRegs finished");
	endtask : testRegs
	task automatic testF2d;
		strapNt <= 1'h1;
		// Settling wait shrunk to a few cycles, as nothing here models it
		repeat (5) @(negedge clock);
		`CHK(ltMode, 1'h0)
		run({12'hA10, 12'h6B7});
		@(negedge clock);
		`CHK(ltMode, 1'h1)
		`CHK(lineTxEn, 1'h0)
		run({12'h889, 12'h90C, 12'hB01});
		poll(8'h0B);
		`CHK(rd, 8'h0B)
		for (int i = 0; i < 4; i++) begin
			push(pat[i]);
			pull();
			`CHK(d, pat[i])
		end
		run({12'hA00, 12'h600, 12'h800, 12'h900});
		poll(8'h00);
		@(negedge clock);
		`CHK(lineTxEn, 1'h1)
		$display("testF2d finished");
	endtask : testF2d
	task automatic testAnalog;
		strapNt <= 1'h0;
		// Modifier bits ahead of the loop enable
		run({12'h701, 12'hDC0, 12'hE22, 12'hF20, 12'h700, 12'hB01});
		hold <= 1'h1;
		@(negedge clock);
		`CHK(sfSyncOe, 1'h1)
		for (int i = 0; i < 4; i++) push(pat[i]);
		@(negedge clock);
		`CHK(dinReady, 1'h0)
		@(posedge clock);
		hold <= 1'h0;
		for (int i = 0; i < 4; i++) begin
			pull();
			`CHK(d, pat[i])
		end
		poll(8'h0B);
		`CHK(rd, 8'h0B)
		run({12'h082, 12'h23C, 12'h442});
		@(negedge clock);
		`CHK(mTx, {8'h42, 8'h82, 8'h3C})
		for (int i = 0; i < 3; i++) begin
			rdIdx(4'(2 * i + 1));
			`CHK(rd, mv[i])
		end
		// Loop off first, modifier bits cleared after
		run({12'h701, 12'hF00, 12'hE00, 12'hD00, 12'h700});
		@(negedge clock);
		`CHK(sfSyncOe, 1'h0)
		poll(8'h00);
		`CHK(rd, 8'h00)
		$display("testAnalog finished");
	endtask : testAnalog
	// One device, its own timing; the byte stream needs no slot setup
	initial begin
		repeat (20) @(posedge clock);
		srst <= 1'h0;
		testRegs();
		testF2d();
		testAnalog();
		completeRun();
	end
endmodule : u_loopback_control_test
